/* verilog/nsg_pkg.sv */
// Package for the negative sequence overcurrent guard.
// Assumes a 10 MHz system clock and a plain byte-addressed register port.
package nsg_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned MS_TICK_CYCLES  = CLK_HZ / MS_PER_S;

  // Register byte addresses
  localparam logic [7:0] NSG_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] NSG_GNOM_ADDR    = 8'h04;
  localparam logic [7:0] NSG_K_ADDR       = 8'h08;
  localparam logic [7:0] NSG_COOL_ADDR    = 8'h0C;
  localparam logic [7:0] NSG_WTHR_ADDR    = 8'h10;
  localparam logic [7:0] NSG_ITHR_ADDR    = 8'h14;
  localparam logic [7:0] NSG_WDEL_ADDR    = 8'h18;
  localparam logic [7:0] NSG_TDEL_ADDR    = 8'h1C;
  localparam logic [7:0] NSG_STAT_ADDR    = 8'h20;
  localparam logic [7:0] NSG_INTHI_ADDR   = 8'h24;
  localparam logic [7:0] NSG_INTLO_ADDR   = 8'h28;

  // Control fields
  localparam int unsigned CTRL_ON_BIT     = 0;
  localparam int unsigned CTRL_SONLY_BIT  = 1;

  // Setting limits and defaults, tenths of % or tenths of s, or ms
  localparam logic [15:0] GNOM_MIN = 16'h00C8;  // 20.0 %
  localparam logic [15:0] GNOM_MAX = 16'h05DC;  // 150.0 %
  localparam logic [15:0] GNOM_DEF = 16'h03E8;  // 100.0 %
  localparam logic [15:0] K_MIN    = 16'h000A;  // 1.0 s
  localparam logic [15:0] K_MAX    = 16'h1388;  // 500.0 s
  localparam logic [15:0] K_DEF    = 16'h0064;  // 10.0 s
  localparam logic [15:0] COOL_MIN = 16'h000A;
  localparam logic [15:0] COOL_MAX = 16'h1388;
  localparam logic [15:0] COOL_DEF = 16'h03E8;  // 100.0 s
  localparam logic [15:0] THR_MIN  = 16'h0014;  // 2.0 %
  localparam logic [15:0] THR_MAX  = 16'h01F4;  // 50.0 %
  localparam logic [15:0] WTHR_DEF = 16'h0028;  // 4.0 %
  localparam logic [15:0] ITHR_DEF = 16'h0032;  // 5.0 %
  localparam logic [15:0] DEL_MIN  = 16'h003C;  // 60 ms
  localparam logic [15:0] DEL_MAX  = 16'h7530;  // 30000 ms
  localparam logic [15:0] WDEL_DEF = 16'h03E8;  // 1000 ms
  localparam logic [15:0] TDEL_DEF = 16'h0064;  // 100 ms

  // Drop-off ratios in percent
  localparam logic [7:0] INV_RESET_PCT  = 8'h5A;  // 90
  localparam logic [7:0] DT_RESET_PCT   = 8'h5F;  // 95
  localparam logic [7:0] PCT_FULL       = 8'h64;  // 100
  // Tenths-of-second to ms scale
  localparam logic [7:0] TENTHS_TO_MS   = 8'h64;

  typedef struct packed {
    logic        on;
    logic        start_only;
    logic [15:0] gnom;
    logic [15:0] k;
    logic [15:0] cool;
    logic [15:0] wthr;
    logic [15:0] ithr;
    logic [15:0] wdel;
    logic [15:0] tdel;
  } nsg_settings_t;

  typedef struct packed {
    logic warn_expired;
    logic warn_pickup;
    logic main_trip;
    logic main_pickup;
  } nsg_flags_t;

endpackage : nsg_pkg

/* verilog/nsg_guard.sv */
// Negative sequence overcurrent guard for a generator: thermal integral,
// main inverse stage and definite-time warning stage with a register port.
// Assumes the estimator delivers I2 in tenths of % of CT rated current.
`timescale 1ns/100ps

// What this block does
// - Mode Off or On, default Off; Off silences every status output.
// - Start-only setting, default 0; when 1 the trip output never asserts.
// - Generator rated current 20 to 150 % of CT, default 100, scales thresholds.
// - K 1 to 500 s, default 10: trip time at rated negative current.
// - Cooling time 1 to 500 s, default 100, sets linear decrease rate.
// - Warning threshold 2 to 50 % of rated current, default 4.
// - Integration threshold 2 to 50 %, default 5; integrate only above it.
// - Warning delay 60 to 30000 ms, default 1000.
// - Trip minimum delay 60 to 30000 ms, default 100, after start.
// - Drive main stage pickup output.
// - Drive main stage trip output.
// - Drive warning pickup output.
// - Drive warning expired output after the warning delay.
// - Blocking input from user logic disables the whole function.
// - Drop-off ratio 0.9 for inverse stage, 0.95 for warning stage.
// - Above threshold, accumulate I2 squared; rated current fills 100 % in K.
// - Below threshold, integral falls linearly; 100 % empties in cooling time.
// - Integration continues after trip but saturates at 200 %.
// - Trip stays active until the integral falls below 90 %.
module nsg_guard #(
  parameter int unsigned TICK_CYCLES = nsg_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // Register port
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [31:0]         reg_rdata_o,
  // Measurement and user logic
  input  wire logic [15:0]         neg_seq_current_i,
  input  wire logic                neg_seq_valid_i,
  input  wire logic                function_block_input_i,
  // Status outputs
  output nsg_pkg::nsg_flags_t      flags_o
);
  import nsg_pkg::*;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo)
    begin
      r = lo;
    end
    else if (v > hi)
    begin
      r = hi;
    end
    return r;
  endfunction : clamp16

  // Current relative threshold test: i2 * 1000 vs pct_tenths * gnom_tenths
  function automatic logic [47:0] scaled_i2(input logic [15:0] i2,
                                            input logic [7:0]  pct);
    return 48'(i2) * 48'(1000) * 48'(pct);
  endfunction : scaled_i2

  function automatic logic [47:0] scaled_thr(input logic [15:0] thr,
                                             input logic [15:0] gnom,
                                             input logic [7:0]  pct);
    return 48'(thr) * 48'(gnom) * 48'(pct);
  endfunction : scaled_thr

  typedef enum logic [1:0] {
    NSG_IDLE,
    NSG_HEAT,
    NSG_TRIPPED
  } nsg_state_t;

  nsg_settings_t set_r;
  nsg_state_t    state_r;
  nsg_state_t    state_nxt;
  logic [15:0]   i2_r;
  logic [31:0]   tick_cnt_r;
  logic          tick;
  logic [63:0]   integ_r;
  logic [63:0]   integ_nxt;
  logic [15:0]   main_tmr_r;
  logic [15:0]   warn_tmr_r;
  logic          int_pick_r;
  logic          warn_pick_r;
  logic          warn_exp_r;
  logic          trip_r;
  logic [31:0]   rdata_r;
  nsg_flags_t    flags_r;

  // Register decode
  wire logic wr_ctrl = reg_wr_i && (reg_addr_i == NSG_CTRL_ADDR);
  wire logic wr_gnom = reg_wr_i && (reg_addr_i == NSG_GNOM_ADDR);
  wire logic wr_k    = reg_wr_i && (reg_addr_i == NSG_K_ADDR);
  wire logic wr_cool = reg_wr_i && (reg_addr_i == NSG_COOL_ADDR);
  wire logic wr_wthr = reg_wr_i && (reg_addr_i == NSG_WTHR_ADDR);
  wire logic wr_ithr = reg_wr_i && (reg_addr_i == NSG_ITHR_ADDR);
  wire logic wr_wdel = reg_wr_i && (reg_addr_i == NSG_WDEL_ADDR);
  wire logic wr_tdel = reg_wr_i && (reg_addr_i == NSG_TDEL_ADDR);
  wire logic wr_param = wr_ctrl | wr_gnom | wr_k | wr_cool | wr_wthr
                        | wr_ithr | wr_wdel | wr_tdel;
  wire logic [15:0] wd16 = reg_wdata_i[15:0];

  // Function enabled only when switched on and not blocked
  wire logic active = set_r.on && !function_block_input_i;

  // Threshold comparisons with drop-off hysteresis
  wire logic [47:0] i2_full   = scaled_i2(i2_r, PCT_FULL);
  wire logic [47:0] ithr_on   = scaled_thr(set_r.ithr, set_r.gnom, PCT_FULL);
  wire logic [47:0] ithr_off  = scaled_thr(set_r.ithr, set_r.gnom, INV_RESET_PCT);
  wire logic [47:0] wthr_on   = scaled_thr(set_r.wthr, set_r.gnom, PCT_FULL);
  wire logic [47:0] wthr_off  = scaled_thr(set_r.wthr, set_r.gnom, DT_RESET_PCT);
  wire logic int_pick_nxt  = active && (int_pick_r ? (i2_full >= ithr_off)
                                                    : (i2_full > ithr_on));
  wire logic warn_pick_nxt = active && (warn_pick_r ? (i2_full >= wthr_off)
                                                     : (i2_full > wthr_on));

  // Thermal integral: heat x^2*cool per ms, cool g^2*K per ms,
  // so 100 % is g^2*K*cool*100 and no divider is needed.
  wire logic [63:0] gsq      = 64'(set_r.gnom) * 64'(set_r.gnom);
  wire logic [63:0] heat_inc = 64'(i2_r) * 64'(i2_r) * 64'(set_r.cool);
  wire logic [63:0] cool_dec = gsq * 64'(set_r.k);
  wire logic [63:0] full_val = cool_dec * 64'(set_r.cool) * 64'(TENTHS_TO_MS);
  wire logic [63:0] sat_val  = {full_val[62:0], 1'b0};
  wire logic [63:0] heated   = integ_r + heat_inc;
  wire logic [63:0] trip_lo  = full_val * 64'(INV_RESET_PCT);
  wire logic [63:0] integ_pc = integ_r * 64'(PCT_FULL);
  wire logic        below_90 = integ_pc < trip_lo;
  wire logic        full_hit = integ_r >= full_val;
  wire logic        min_done = main_tmr_r >= set_r.tdel;

  always_comb
  begin
    integ_nxt = integ_r;
    if (tick)
    begin
      if (int_pick_r)
      begin
        integ_nxt = (heated > sat_val) ? sat_val : heated;
      end
      else
      begin
        integ_nxt = (integ_r > cool_dec) ? integ_r - cool_dec : 64'h0000_0000_0000_0000;
      end
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      NSG_IDLE:
      begin
        if (int_pick_r)
        begin
          state_nxt = NSG_HEAT;
        end
      end
      NSG_HEAT:
      begin
        if (!int_pick_r)
        begin
          state_nxt = NSG_IDLE;
        end
        else if (full_hit && min_done)
        begin
          state_nxt = NSG_TRIPPED;
        end
      end
      NSG_TRIPPED:
      begin
        if (!active || below_90)
        begin
          state_nxt = int_pick_r ? NSG_HEAT : NSG_IDLE;
        end
      end
      default:
      begin
        state_nxt = NSG_IDLE;
      end
    endcase
  end

  // Millisecond time base
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || tick)
    begin
      tick_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Latest estimator sample, held between updates
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      i2_r <= 16'h0000;
    end
    else if (neg_seq_valid_i)
    begin
      i2_r <= neg_seq_current_i;
    end
  end

  // Settings registers, clamped to their ranges
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      set_r.on         <= 1'b0;
      set_r.start_only <= 1'b0;
      set_r.gnom       <= GNOM_DEF;
      set_r.k          <= K_DEF;
      set_r.cool       <= COOL_DEF;
      set_r.wthr       <= WTHR_DEF;
      set_r.ithr       <= ITHR_DEF;
      set_r.wdel       <= WDEL_DEF;
      set_r.tdel       <= TDEL_DEF;
    end
    else
    begin
      if (wr_ctrl)
      begin
        set_r.on         <= reg_wdata_i[CTRL_ON_BIT];
        set_r.start_only <= reg_wdata_i[CTRL_SONLY_BIT];
      end
      if (wr_gnom) set_r.gnom <= clamp16(wd16, GNOM_MIN, GNOM_MAX);
      if (wr_k)    set_r.k    <= clamp16(wd16, K_MIN, K_MAX);
      if (wr_cool) set_r.cool <= clamp16(wd16, COOL_MIN, COOL_MAX);
      if (wr_wthr) set_r.wthr <= clamp16(wd16, THR_MIN, THR_MAX);
      if (wr_ithr) set_r.ithr <= clamp16(wd16, THR_MIN, THR_MAX);
      if (wr_wdel) set_r.wdel <= clamp16(wd16, DEL_MIN, DEL_MAX);
      if (wr_tdel) set_r.tdel <= clamp16(wd16, DEL_MIN, DEL_MAX);
    end
  end

  // Integral keeps history across pickups; a parameter load wipes it
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || wr_param)
    begin
      integ_r <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      integ_r <= integ_nxt;
    end
  end

  // Pickup state and stage timers
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_r     <= NSG_IDLE;
      int_pick_r  <= 1'b0;
      warn_pick_r <= 1'b0;
      main_tmr_r  <= 16'h0000;
      warn_tmr_r  <= 16'h0000;
    end
    else
    begin
      state_r     <= active ? state_nxt : NSG_IDLE;
      int_pick_r  <= int_pick_nxt;
      warn_pick_r <= warn_pick_nxt;
      if (!int_pick_r)
      begin
        main_tmr_r <= 16'h0000;
      end
      else if (tick && !min_done)
      begin
        main_tmr_r <= main_tmr_r + 16'h0001;
      end
      // Any dropout restarts the warning delay
      if (!warn_pick_r)
      begin
        warn_tmr_r <= 16'h0000;
      end
      else if (tick && (warn_tmr_r < set_r.wdel))
      begin
        warn_tmr_r <= warn_tmr_r + 16'h0001;
      end
    end
  end

  assign trip_r     = (state_r == NSG_TRIPPED);
  assign warn_exp_r = warn_pick_r && (warn_tmr_r >= set_r.wdel);

  // Outputs registered; start-only suppresses the trip command
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      flags_r <= '0;
    end
    else
    begin
      flags_r.main_pickup  <= active && int_pick_r;
      flags_r.main_trip    <= active && trip_r && !set_r.start_only;
      flags_r.warn_pickup  <= active && warn_pick_r;
      flags_r.warn_expired <= active && warn_exp_r;
    end
  end

  assign flags_o = flags_r;

  // Read path: data in the cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !reg_rd_i)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      case (reg_addr_i)
        NSG_CTRL_ADDR:  rdata_r <= {30'h0000_0000, set_r.start_only, set_r.on};
        NSG_GNOM_ADDR:  rdata_r <= {16'h0000, set_r.gnom};
        NSG_K_ADDR:     rdata_r <= {16'h0000, set_r.k};
        NSG_COOL_ADDR:  rdata_r <= {16'h0000, set_r.cool};
        NSG_WTHR_ADDR:  rdata_r <= {16'h0000, set_r.wthr};
        NSG_ITHR_ADDR:  rdata_r <= {16'h0000, set_r.ithr};
        NSG_WDEL_ADDR:  rdata_r <= {16'h0000, set_r.wdel};
        NSG_TDEL_ADDR:  rdata_r <= {16'h0000, set_r.tdel};
        NSG_STAT_ADDR:  rdata_r <= {27'h000_0000, trip_r, flags_r};
        NSG_INTHI_ADDR: rdata_r <= integ_r[63:32];
        NSG_INTLO_ADDR: rdata_r <= integ_r[31:0];
        default:        rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule : nsg_guard

/* verif/nsg_guard_asserts.sv */
// Port checker for nsg_guard, bound to every instance of it.
// Assumes both delay settings sit at their defaults while flags rise.
`timescale 1ns/100ps
module nsg_guard_asserts #(
  parameter int unsigned TICK_CYCLES = nsg_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  // Register port
  input wire logic [7:0]          reg_addr_i,
  input wire logic [31:0]         reg_wdata_i,
  input wire logic                reg_wr_i,
  input wire logic                reg_rd_i,
  input wire logic [31:0]         reg_rdata_o,
  // Measurement and user logic
  input wire logic [15:0]         neg_seq_current_i,
  input wire logic                neg_seq_valid_i,
  input wire logic                function_block_input_i,
  // Status outputs
  input wire nsg_pkg::nsg_flags_t flags_o
);
  import nsg_pkg::*;
  // Two ticks of slack: the first tick may land just after pickup
  localparam int unsigned TRIP_MIN = (int'(TDEL_DEF) - 2) * TICK_CYCLES;
  localparam int unsigned WARN_MIN = (int'(WDEL_DEF) - 2) * TICK_CYCLES;
  logic [1:0]  ctrl_r;
  int unsigned pk_cnt_r;
  int unsigned wp_cnt_r;
  logic        on_ok;
  assign on_ok = ctrl_r[0] && !function_block_input_i;
  always_ff @(posedge clk_sys_i)
    ctrl_r <= rst_i ? 2'h0 : (reg_wr_i && reg_addr_i == NSG_CTRL_ADDR) ? reg_wdata_i[1:0] : ctrl_r;
  always_ff @(posedge clk_sys_i)
    pk_cnt_r <= (rst_i || !flags_o.main_pickup) ? 0 : pk_cnt_r + 1;
  always_ff @(posedge clk_sys_i)
    wp_cnt_r <= (rst_i || !flags_o.warn_pickup) ? 0 : wp_cnt_r + 1;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  sequence s_hot;
    on_ok ##1 (on_ok && neg_seq_valid_i && neg_seq_current_i > 16'h0400)
      ##1 (on_ok && !neg_seq_valid_i) [*3];
  endsequence
  // Below the lowest hold level that any clamped setting pair allows
  sequence s_cold;
    (neg_seq_valid_i && neg_seq_current_i < 16'h0003) ##1 (!neg_seq_valid_i) [*3];
  endsequence
  pickup_rise_a: assert property (s_hot |-> flags_o.main_pickup && flags_o.warn_pickup)
    else $error("pickup flags missing after a high sample");
  pickup_drop_a: assert property (s_cold |-> !flags_o.main_pickup && !flags_o.warn_pickup)
    else $error("pickup flags held after a low sample");
  off_silent_a: assert property (!ctrl_r[0] [*3] |-> flags_o == 4'h0)
    else $error("flag raised while switched off");
  start_only_a: assert property (ctrl_r[1] [*3] |-> !flags_o.main_trip)
    else $error("trip raised in start-only mode");
  block_clear_a: assert property (function_block_input_i [*3] |-> flags_o == 4'h0)
    else $error("flag raised while blocked");
  trip_delay_a: assert property ($rose(flags_o.main_trip) |-> pk_cnt_r >= TRIP_MIN)
    else $error("trip before the minimum delay");
  warn_delay_a: assert property ($rose(flags_o.warn_expired) |-> wp_cnt_r >= WARN_MIN)
    else $error("warning expired before its delay");
  status_read_a:
    assert property (reg_rd_i && reg_addr_i == NSG_STAT_ADDR |=> reg_rdata_o[3:0] == $past(flags_o))
    else $error("status read differs from flags");
endmodule : nsg_guard_asserts

bind nsg_guard nsg_guard_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_nsg_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .neg_seq_current_i(neg_seq_current_i), .neg_seq_valid_i(neg_seq_valid_i),
  .function_block_input_i(function_block_input_i), .flags_o(flags_o)
);

/* verif/nsg_estimator_model.sv */
// Upstream I2 estimator model: one magnitude per processing cycle.
// Assumes the bench sets the wanted level; period is the ms tick.
`timescale 1ns/100ps
module nsg_estimator_model #(
  parameter int unsigned PERIOD = 10
) (
  // Clock and reset
  input  wire logic   clk_sys_i,
  input  wire logic   rst_i,
  // Wanted magnitude
  input  wire logic [15:0] level_i,
  // Estimator output
  output logic [15:0] current_o = 16'h0000,
  output logic        valid_o = 1'b0
);
  int unsigned cnt_r = 0;
  always @(posedge clk_sys_i)
  begin
    cnt_r <= (rst_i || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
    valid_o <= !rst_i && cnt_r == 0;
    // Stale between samples, so show a moving pattern
    current_o <= (cnt_r == 0) ? level_i : ~current_o;
  end
endmodule : nsg_estimator_model

/* verif/testbench.sv */
// Self-checking bench: estimator model feeds I2, tasks drive the register port.
// Assumes a 10-cycle ms tick so that second-scale settings run short.
`timescale 1ns/100ps
module testbench;
  import nsg_pkg::*;
  localparam int unsigned TK = 10;
  localparam logic [63:0] FULL = 64'(GNOM_DEF) * GNOM_DEF * K_MIN * COOL_MIN * PCT_FULL;
  localparam logic [63:0] STEP = 64'(GNOM_DEF) * GNOM_DEF * K_MIN;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        blk_r = 1'b0;
  logic [15:0] lvl_r = 16'h0000;
  logic [31:0] rnd_r = 32'h0000_358C;
  logic [31:0] reg_rdata_o;
  logic [31:0] d;
  logic [63:0] q;
  logic [15:0] cur;
  logic        vld;
  nsg_flags_t  flags_o;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          n;
  logic [15:0] dfl [8] = '{16'h0000, GNOM_DEF, K_DEF, COOL_DEF, WTHR_DEF, ITHR_DEF, WDEL_DEF,
    TDEL_DEF};
  // Address, value written, value read back after clamping
  logic [39:0] cl [8] = '{{NSG_GNOM_ADDR, 16'hFFFF, GNOM_MAX}, {NSG_GNOM_ADDR, 16'h0000, GNOM_MIN},
    {NSG_K_ADDR, 16'h0000, K_MIN}, {NSG_COOL_ADDR, 16'h2000, COOL_MAX},
    {NSG_WTHR_ADDR, 16'h0001, THR_MIN}, {NSG_ITHR_ADDR, 16'hFFFF, THR_MAX},
    {NSG_WDEL_ADDR, 16'h0000, DEL_MIN}, {NSG_TDEL_ADDR, 16'hFFFF, DEL_MAX}};
  always #50 clk_sys_i = ~clk_sys_i;
  nsg_guard #(.TICK_CYCLES(TK)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .neg_seq_current_i(cur),
    .neg_seq_valid_i(vld), .function_block_input_i(blk_r), .flags_o(flags_o));
  nsg_estimator_model #(.PERIOD(TK)) u_est (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .level_i(lvl_r), .current_o(cur), .valid_o(vld));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [63:0] heat(input logic [15:0] i2);
    return 64'(i2) * i2 * COOL_MIN;
  endfunction : heat
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Data stand one cycle only, so take them at the following edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    v = reg_rdata_o;
  endtask : rd
  // Halves are not atomic; callers read only where the high half holds
  task automatic rdi(output logic [63:0] v);
    rd(NSG_INTHI_ADDR, v[63:32]);
    rd(NSG_INTLO_ADDR, v[31:0]);
  endtask : rdi
  task automatic wt(input int b, input logic v, input int lim);
    n = 0;
    while (flags_o[b] !== v)
    begin
      @(posedge clk_sys_i);
      n++;
      if (n > lim)
      begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask : wt
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4), d);
      chk(d, dfl[i]);
    end
    // Clamp writes only after every default is read, else gnom is already moved
    for (int i = 0; i < 8; i++)
    begin
      wr(cl[i][39:32], 32'(cl[i][31:16]));
      rd(cl[i][39:32], d);
      chk(d, cl[i][15:0]);
    end
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, d);
    chk(d, 32'h0000_0000);
    repeat (4)
    begin
      rnd_r = xs(rnd_r);
      q = 64'(GNOM_MIN) + rnd_r % 32'h0000_0515;
      wr(NSG_GNOM_ADDR, q[31:0]);
      rd(NSG_GNOM_ADDR, d);
      chk(d, q);
    end
    for (int i = 1; i < 8; i++)
      wr(8'(i * 4), 32'(i == 2 ? K_MIN : i == 3 ? COOL_MIN : dfl[i]));
    repeat (20)
    begin
      rnd_r = xs(rnd_r);
      lvl_r <= rnd_r[15:0];
      repeat (TK) @(posedge clk_sys_i);
      chk(flags_o, 4'h0);
    end
    lvl_r <= 16'h07D0;
    // Let the level land while still off, so no stale random sample heats
    repeat (2 * TK) @(posedge clk_sys_i);
    wr(NSG_CTRL_ADDR, 32'h0000_0003);
    wt(0, 1'b1, 50);
    chk(flags_o.warn_pickup, 1'b1);
    repeat (5 * TK) @(posedge clk_sys_i);
    rdi(q);
    chk(q % heat(16'h07D0) == 0 && q >= 3 * heat(16'h07D0) && q <= 8 * heat(16'h07D0), 1'b1);
    repeat (3000) @(posedge clk_sys_i);
    chk(flags_o.main_trip, 1'b0);
    rd(NSG_STAT_ADDR, d);
    chk(d[4], 1'b1);
    lvl_r <= 16'h0000;
    repeat (30) @(posedge clk_sys_i);
    wr(NSG_CTRL_ADDR, 32'h0000_0000);
    wr(NSG_CTRL_ADDR, 32'h0000_0001);
    rdi(q);
    chk(q, 64'h0);
    lvl_r <= 16'h2710;
    wt(0, 1'b1, 50);
    wt(1, 1'b1, 2000);
    chk(n + 3 * TK >= TDEL_DEF * TK && n <= TDEL_DEF * TK + 3 * TK, 1'b1);
    rdi(q);
    chk(q, FULL + FULL);
    wt(3, 1'b1, 9500);
    chk(flags_o.warn_pickup, 1'b1);
    lvl_r <= 16'h0000;
    repeat (10000) @(posedge clk_sys_i);
    chk(flags_o.main_trip, 1'b1);
    wt(1, 1'b0, 2000);
    rdi(q);
    chk(q < FULL * INV_RESET_PCT / PCT_FULL, 1'b1);
    chk(q + 3 * STEP >= FULL * INV_RESET_PCT / PCT_FULL && q % STEP == 0, 1'b1);
    lvl_r <= 16'h2710;
    wt(2, 1'b1, 50);
    blk_r <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk(flags_o, 4'h0);
    blk_r <= 1'b0;
    lvl_r <= 16'h003C;
    wt(0, 1'b1, 50);
    lvl_r <= 16'h002F;
    repeat (30) @(posedge clk_sys_i);
    chk(flags_o.main_pickup, 1'b1);
    lvl_r <= 16'h002C;
    repeat (30) @(posedge clk_sys_i);
    chk({flags_o.warn_pickup, flags_o.main_pickup}, 2'h2);
    lvl_r <= 16'h0025;
    repeat (30) @(posedge clk_sys_i);
    chk(flags_o.warn_pickup, 1'b0);
    wrap_up();
  end
endmodule : testbench
